// File: rtl/csc_clock_ctrl.sv
// clock source control register block with APB slave and calibration timer

// Operation
// - seven write-one task locations 0x000..0x018 each fire their task.
// - four event registers at 0x100, 0x104, 0x10c, 0x110 report events.
// - 0x408 bit 0 reads one after fast crystal start task.
// - 0x414 bit 0 reads one after slow source start task.
// - 0x40c gives fast source in bit 0, running in bit 16.
// - 0x418 gives slow source in bits 1:0, running in bit 16.
// - slow start task latches current source selection into 0x41c.
// - 0x518 bits 1:0 select slow source, reset zero.
// - 0x538 holds seven-bit interval in quarter-second units.
// - 0x550 bits 7:0 pick crystal: 0xff 16 MHz, 0x00 32 MHz.
// - source select changes only while slow start is not requested.
// - timer counts down from interval, times out at zero, stops.
module csc_clock_ctrl
    import csc_pkg::*;
#(
    parameter longint UNIT_CYCLES = CT_UNIT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        fast_xtal_ready,
    input  wire logic        slow_clock_ready,
    input  wire logic        cal_complete,
    output logic             fast_xtal_enable,
    output logic             slow_source_enable,
    output logic      [1:0]  slow_source_sel,
    output logic             cal_request,
    output logic      [7:0]  crystal_frequency_select
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_d;

    // pins come from the analog side, two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_d <= 3'h0;
        end else begin
            sync_a <= {cal_complete, slow_clock_ready, fast_xtal_ready};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    // ****************************************
    // bus decode
    // ****************************************
    logic wr_acc;
    logic rd_setup;
    logic wr_one;

    // writes land in the access phase; reads are fetched in setup
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_one   = pwdata[0];
    assign pready   = 1'b1;

    logic t_hf_start;
    logic t_hf_stop;
    logic t_lf_start;
    logic t_lf_stop;
    logic t_cal;
    logic t_ct_start;
    logic t_ct_stop;

    // each task is a single-cycle strobe on a write of one
    assign t_hf_start = wr_acc & wr_one & (paddr == OFS_TASK_HF_XTAL_START);
    assign t_hf_stop  = wr_acc & wr_one & (paddr == OFS_TASK_HF_XTAL_STOP);
    assign t_lf_start = wr_acc & wr_one & (paddr == OFS_TASK_LF_SOURCE_START);
    assign t_lf_stop  = wr_acc & wr_one & (paddr == OFS_TASK_LF_SOURCE_STOP);
    assign t_cal      = wr_acc & wr_one & (paddr == OFS_TASK_RC_CALIBRATE);
    assign t_ct_start = wr_acc & wr_one & (paddr == OFS_TASK_CAL_TIMER_START);
    assign t_ct_stop  = wr_acc & wr_one & (paddr == OFS_TASK_CAL_TIMER_STOP);

    // ****************************************
    // control and configuration state
    // ****************************************
    logic       hf_run;
    logic       lf_run;
    logic [1:0] lf_select;
    logic [1:0] lf_copy;
    logic [6:0] ct_interval;
    logic [4:0] irq_mask;
    logic [3:0] events;
    logic       next_hf_run;
    logic       next_lf_run;
    logic [1:0] next_lf_select;
    logic [1:0] next_lf_copy;
    logic [6:0] next_ct_interval;
    logic [7:0] next_xtal;
    logic [4:0] next_irq_mask;
    logic [3:0] next_events;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic       hf_running;
    logic       lf_running;
    logic       ct_timeout;

    // the oscillators are modelled only by their ready pins
    assign hf_running = hf_run & sync_b[0];
    assign lf_running = lf_run & sync_b[1];

    // event sources: rising readiness while requested, done pin, timer
    assign ev_set = {ct_timeout, sync_b[2] & ~sync_d[2],
                     lf_running & ~sync_d[1], hf_running & ~sync_d[0]};
    assign ev_clr = {wr_acc & ~wr_one & (paddr == OFS_EVENT_CAL_TIMER_TO),
                     wr_acc & ~wr_one & (paddr == OFS_EVENT_CAL_COMPLETE),
                     wr_acc & ~wr_one & (paddr == OFS_EVENT_LF_STARTED),
                     wr_acc & ~wr_one & (paddr == OFS_EVENT_HF_STARTED)};

    // next values of all software-visible state
    always_comb begin
        next_hf_run      = hf_run;
        next_lf_run      = lf_run;
        next_lf_select   = lf_select;
        next_lf_copy     = lf_copy;
        next_ct_interval = ct_interval;
        next_xtal        = crystal_frequency_select;
        next_irq_mask    = irq_mask;
        // a new event beats a clear in the same cycle
        next_events      = (events & ~ev_clr) | ev_set;
        if (t_hf_start) begin
            next_hf_run = 1'b1;
        end else if (t_hf_stop) begin
            next_hf_run = 1'b0;
        end
        if (t_lf_start) begin
            next_lf_run  = 1'b1;
            next_lf_copy = lf_select;
        end else if (t_lf_stop) begin
            next_lf_run = 1'b0;
        end
        // select is frozen while the slow clock is requested
        if (wr_acc && paddr == OFS_LF_SOURCE_SELECT && !lf_run) begin
            next_lf_select = pwdata[1:0];
        end
        if (wr_acc && paddr == OFS_CAL_TIMER_INTERVAL) begin
            next_ct_interval = pwdata[CAL_TIMER_INTERVAL_W-1:0];
        end
        if (wr_acc && paddr == OFS_CRYSTAL_FREQ_SELECT) begin
            next_xtal = pwdata[7:0];
        end
        if (wr_acc && paddr == OFS_IRQ_ENABLE_SET) begin
            next_irq_mask = irq_mask | {pwdata[4:3], 1'b0, pwdata[1:0]};
        end
        if (wr_acc && paddr == OFS_IRQ_ENABLE_CLEAR) begin
            next_irq_mask = irq_mask & ~({pwdata[4:3], 1'b0, pwdata[1:0]});
        end
    end

    // registers for the state above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_run                   <= 1'b0;
            lf_run                   <= 1'b0;
            lf_select                <= LF_SRC_RESET;
            lf_copy                  <= LF_SRC_RESET;
            ct_interval              <= CAL_TIMER_INTERVAL_RESET;
            crystal_frequency_select <= XTAL_FREQ_RESET;
            irq_mask                 <= IRQ_MASK_RESET;
            events                   <= 4'h0;
        end else begin
            hf_run                   <= next_hf_run;
            lf_run                   <= next_lf_run;
            lf_select                <= next_lf_select;
            lf_copy                  <= next_lf_copy;
            ct_interval              <= next_ct_interval;
            crystal_frequency_select <= next_xtal;
            irq_mask                 <= next_irq_mask;
            events                   <= next_events;
        end
    end

    // enables follow the run flags, source select the latched copy; calibration is a strobe
    assign fast_xtal_enable   = hf_run;
    assign slow_source_enable = lf_run;
    assign slow_source_sel    = lf_copy;
    assign cal_request        = t_cal;

    // one level output over the enabled events
    assign irq = |({events[3:2], 1'b0, events[1:0]} & irq_mask);

    // ****************************************
    // calibration timer
    // ****************************************
    localparam int UW = $clog2(UNIT_CYCLES + 1);
    csc_ct_state_e ct_state;
    csc_ct_state_e next_ct_state;
    logic [6:0]    ct_count;
    logic [6:0]    next_ct_count;
    logic [UW-1:0] unit_cnt;
    logic [UW-1:0] next_unit_cnt;
    logic          unit_tick;

    // one quarter-second unit elapses when the prescaler wraps
    assign unit_tick  = (unit_cnt == UW'(UNIT_CYCLES - 1));
    assign ct_timeout = (ct_state == CSC_CT_COUNT) && unit_tick && (ct_count <= 7'h01);

    // stop wins over start; a zero interval times out on the first unit
    always_comb begin
        next_ct_state = ct_state;
        next_ct_count = ct_count;
        next_unit_cnt = unit_tick ? '0 : unit_cnt + 1'b1;
        unique case (ct_state)
            CSC_CT_IDLE: begin
                next_unit_cnt = '0;
                if (t_ct_start && !t_ct_stop) begin
                    next_ct_state = CSC_CT_COUNT;
                    next_ct_count = ct_interval;
                end
            end
            CSC_CT_COUNT: begin
                if (t_ct_stop) begin
                    next_ct_state = CSC_CT_IDLE;
                end else if (t_ct_start) begin
                    next_ct_count = ct_interval;
                    next_unit_cnt = '0;
                end else if (ct_timeout) begin
                    next_ct_state = CSC_CT_IDLE;
                end else if (unit_tick) begin
                    next_ct_count = ct_count - 7'h01;
                end
            end
        endcase
    end

    // timer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_state <= CSC_CT_IDLE;
            ct_count <= 7'h00;
            unit_cnt <= '0;
        end else begin
            ct_state <= next_ct_state;
            ct_count <= next_ct_count;
            unit_cnt <= next_unit_cnt;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] rd_val;
    logic        rd_hit;
    logic        next_err;

    // unmapped addresses read zero and flag an error
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_TASK_HF_XTAL_START, OFS_TASK_HF_XTAL_STOP,
            OFS_TASK_LF_SOURCE_START, OFS_TASK_LF_SOURCE_STOP,
            OFS_TASK_RC_CALIBRATE, OFS_TASK_CAL_TIMER_START,
            OFS_TASK_CAL_TIMER_STOP:    rd_val = 32'h0000_0000;
            OFS_EVENT_HF_STARTED:       rd_val = {31'h0, events[0]};
            OFS_EVENT_LF_STARTED:       rd_val = {31'h0, events[1]};
            OFS_EVENT_CAL_COMPLETE:     rd_val = {31'h0, events[2]};
            OFS_EVENT_CAL_TIMER_TO:     rd_val = {31'h0, events[3]};
            OFS_IRQ_ENABLE_SET,
            OFS_IRQ_ENABLE_CLEAR:       rd_val = {27'h0, irq_mask};
            OFS_HF_START_REQUESTED:     rd_val = {31'h0, hf_run};
            OFS_HF_SOURCE_STATUS: begin
                rd_val[0]         = hf_running;
                rd_val[STATE_BIT] = hf_running;
            end
            OFS_LF_START_REQUESTED:     rd_val = {31'h0, lf_run};
            OFS_LF_SOURCE_STATUS: begin
                rd_val[1:0]       = lf_running ? lf_copy : LF_SRC_RC;
                rd_val[STATE_BIT] = lf_running;
            end
            OFS_LF_SOURCE_LATCHED:      rd_val = {30'h0, lf_copy};
            OFS_LF_SOURCE_SELECT:       rd_val = {30'h0, lf_select};
            OFS_CAL_TIMER_INTERVAL:     rd_val = {25'h0, ct_interval};
            OFS_CRYSTAL_FREQ_SELECT:    rd_val = {24'h0, crystal_frequency_select};
            default:                    rd_hit = 1'b0;
        endcase
        next_err = ~rd_hit;
    end

    // read data and error are captured in setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= rd_setup ? rd_val : 32'h0000_0000;
            pslverr <= next_err;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_hf_run;
        @(posedge pclk) disable iff (!presetn)
        t_hf_start |=> hf_run ##0 fast_xtal_enable;
    endproperty
    a_hf_run: assert property (p_hf_run) else $error("fast start not recorded");

    property p_lf_run;
        @(posedge pclk) disable iff (!presetn)
        t_lf_start |=> lf_run && slow_source_enable;
    endproperty
    a_lf_run: assert property (p_lf_run) else $error("slow start not recorded");

    property p_copy;
        @(posedge pclk) disable iff (!presetn)
        t_lf_start |=> lf_copy == $past(lf_select);
    endproperty
    a_copy: assert property (p_copy) else $error("source copy not latched");

    property p_sel_lock;
        @(posedge pclk) disable iff (!presetn)
        lf_run && wr_acc && paddr == OFS_LF_SOURCE_SELECT |=> $stable(lf_select);
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("select changed while running");

    property p_ct_stop;
        @(posedge pclk) disable iff (!presetn)
        // a timeout in the stop cycle still raises its event, so it is left out here
        t_ct_stop && !ct_timeout |=> ct_state == CSC_CT_IDLE && $stable(events[3]);
    endproperty
    a_ct_stop: assert property (p_ct_stop) else $error("timer not stopped");

    property p_ct_to;
        @(posedge pclk) disable iff (!presetn)
        ct_state == CSC_CT_COUNT && unit_tick && ct_count == 7'h01 && !t_ct_stop
            && !t_ct_start |=> events[3] && ct_state == CSC_CT_IDLE;
    endproperty
    a_ct_to: assert property (p_ct_to) else $error("timeout missed");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        events[0] && !ev_clr[0] |=> events[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event lost");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        $rose(events[3]) && irq_mask[IRQ_BIT_CT] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_mask_set;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == OFS_IRQ_ENABLE_SET && pwdata[IRQ_BIT_CAL] |=> irq_mask[IRQ_BIT_CAL];
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("enable set failed");

    property p_ev_read;
        @(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == OFS_EVENT_HF_STARTED |=> prdata[0] == $past(events[0]);
    endproperty
    a_ev_read: assert property (p_ev_read) else $error("event readback wrong");

    property p_xtal;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == OFS_CRYSTAL_FREQ_SELECT
            |=> crystal_frequency_select == $past(pwdata[7:0]);
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal select not stored");

    c_timeout: cover property (@(posedge pclk) disable iff (!presetn) ct_timeout);
    c_irq:     cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_lf_up:   cover property (@(posedge pclk) disable iff (!presetn) ev_set[1]);
    c_err:     cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pslverr);

endmodule : csc_clock_ctrl

// File: rtl/csc_pkg.sv
// constants shared by the clock source control register block
package csc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] OFS_TASK_HF_XTAL_START     = 12'h000;
    localparam logic [11:0] OFS_TASK_HF_XTAL_STOP      = 12'h004;
    localparam logic [11:0] OFS_TASK_LF_SOURCE_START   = 12'h008;
    localparam logic [11:0] OFS_TASK_LF_SOURCE_STOP    = 12'h00c;
    localparam logic [11:0] OFS_TASK_RC_CALIBRATE      = 12'h010;
    localparam logic [11:0] OFS_TASK_CAL_TIMER_START   = 12'h014;
    localparam logic [11:0] OFS_TASK_CAL_TIMER_STOP    = 12'h018;
    localparam logic [11:0] OFS_EVENT_HF_STARTED       = 12'h100;
    localparam logic [11:0] OFS_EVENT_LF_STARTED       = 12'h104;
    localparam logic [11:0] OFS_EVENT_CAL_COMPLETE     = 12'h10c;
    localparam logic [11:0] OFS_EVENT_CAL_TIMER_TO     = 12'h110;
    localparam logic [11:0] OFS_IRQ_ENABLE_SET         = 12'h304;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR       = 12'h308;
    localparam logic [11:0] OFS_HF_START_REQUESTED     = 12'h408;
    localparam logic [11:0] OFS_HF_SOURCE_STATUS       = 12'h40c;
    localparam logic [11:0] OFS_LF_START_REQUESTED     = 12'h414;
    localparam logic [11:0] OFS_LF_SOURCE_STATUS       = 12'h418;
    localparam logic [11:0] OFS_LF_SOURCE_LATCHED      = 12'h41c;
    localparam logic [11:0] OFS_LF_SOURCE_SELECT       = 12'h518;
    localparam logic [11:0] OFS_CAL_TIMER_INTERVAL     = 12'h538;
    localparam logic [11:0] OFS_CRYSTAL_FREQ_SELECT    = 12'h550;

    // ****************************************
    // field positions, widths and reset values
    // ****************************************
    localparam int          IRQ_BIT_HF      = 0;
    localparam int          IRQ_BIT_LF      = 1;
    localparam int          IRQ_BIT_CAL     = 3;
    localparam int          IRQ_BIT_CT      = 4;
    localparam int          STATE_BIT       = 16;
    localparam int          CAL_TIMER_INTERVAL_W          = 7;
    localparam logic [4:0]  IRQ_MASK_RESET  = 5'h00;
    localparam logic [1:0]  LF_SRC_RESET    = 2'h0;
    localparam logic [6:0]  CAL_TIMER_INTERVAL_RESET      = 7'h00;
    localparam logic [7:0]  XTAL_FREQ_RESET = 8'h00;

    // slow source encodings, shared by select, copy and status; crystal frequency codes
    localparam logic [1:0]  LF_SRC_RC       = 2'h0;
    localparam logic [1:0]  LF_SRC_XTAL     = 2'h1;
    localparam logic [1:0]  LF_SRC_SYNTH    = 2'h2;
    localparam logic [7:0]  XTAL_16MHZ      = 8'hff;
    localparam logic [7:0]  XTAL_32MHZ      = 8'h00;

    // ****************************************
    // timing: one interval unit and the clock rate
    // ****************************************
    localparam longint CT_UNIT_US     = 250000;
    localparam longint PCLK_MHZ       = 250;
    localparam longint CT_UNIT_CYCLES = CT_UNIT_US * PCLK_MHZ;

    typedef enum logic [0:0] {
        CSC_CT_IDLE  = 1'b0,
        CSC_CT_COUNT = 1'b1
    } csc_ct_state_e;

endpackage : csc_pkg

// File: sim/tb_clock_source_ctrl_regs.sv
// self-checking testbench for the clock source control register block
module tb_clock_source_ctrl_regs;
    import csc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals and counters
    // ****************************************
    localparam longint UNIT = 8;  // short timer unit keeps the run brief
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        fast_xtal_ready, slow_clock_ready, cal_complete;
    logic        fast_xtal_enable, slow_source_enable, cal_request;
    logic [1:0]  slow_source_sel;
    logic [7:0]  crystal_frequency_select;
    logic        last_err;
    int          failures, cmp_count, cal_pulses, n;

    csc_clock_ctrl #(.UNIT_CYCLES(UNIT)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .fast_xtal_ready(fast_xtal_ready),
        .slow_clock_ready(slow_clock_ready), .cal_complete(cal_complete),
        .fast_xtal_enable(fast_xtal_enable), .slow_source_enable(slow_source_enable),
        .slow_source_sel(slow_source_sel), .cal_request(cal_request),
        .crystal_frequency_select(crystal_frequency_select));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // counts cycles of the calibration strobe, which must be one cycle per write of one
    always @(posedge pclk) begin
        if (cal_request === 1'b1) cal_pulses++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // let the write land before the caller looks at any output
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    // waits for irq under a bound; the bound is the only exit if it never rises
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (irq !== 1'b1) begin
            failures++;
            $display("[FAIL] irq expected 1 seen %b", irq);
        end
    endtask : wait_irq

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset_and_fields();
        logic [11:0] ofs [9];
        ofs = '{12'h304, 12'h308, 12'h408, 12'h40c, 12'h414, 12'h418, 12'h41c,
                12'h518, 12'h538};
        foreach (ofs[i]) rdc(ofs[i], 32'h0, "reset value");
        rdc(12'h550, 32'h0, "crystal reset");
        rdc(12'h0fc, 32'h0, "unmapped read");
        chk("unmapped error", 32'h1, {31'h0, last_err});
        apb(1'b1, 12'h538, 32'hffffffff);
        rdc(12'h538, 32'h7f, "interval field");
        apb(1'b1, 12'h550, 32'h000000ff);
        rdc(12'h550, 32'hff, "crystal field");
        chk("crystal port", 32'hff, {24'h0, crystal_frequency_select});
        apb(1'b1, 12'h550, 32'h0);
        chk("crystal port 32", 32'h0, {24'h0, crystal_frequency_select});
    endtask : test_reset_and_fields

    task automatic test_mask_and_cal();
        apb(1'b1, 12'h304, 32'hffffffff);
        rdc(12'h308, 32'h1b, "mask after set");
        apb(1'b1, 12'h308, 32'h00000008);
        rdc(12'h304, 32'h13, "mask after clear");
        cal_pulses = 0;
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h010, 32'h0);
        chk("cal strobe count", 32'h1, cal_pulses);
        cal_complete <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(12'h10c, 32'h1, "cal event");
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h304, 32'h00000008);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h10c, 32'h1);
        rdc(12'h10c, 32'h1, "event write one");
        apb(1'b1, 12'h10c, 32'h0);
        chk("irq after clear", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h308, 32'h0000001f);
    endtask : test_mask_and_cal

    task automatic test_fast_clock();
        apb(1'b1, 12'h304, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        rdc(12'h408, 32'h1, "fast requested");
        chk("fast enable", 32'h1, {31'h0, fast_xtal_enable});
        fast_xtal_ready <= 1'b1;
        wait_irq();
        rdc(12'h100, 32'h1, "fast event");
        rdc(12'h40c, 32'h00010001, "fast status");
        apb(1'b1, 12'h100, 32'h0);
        chk("fast irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h004, 32'h1);
        rdc(12'h408, 32'h0, "fast stopped");
        fast_xtal_ready <= 1'b0;
        apb(1'b1, 12'h308, 32'h1);
    endtask : test_fast_clock

    task automatic test_slow_clock();
        apb(1'b1, 12'h518, {30'h0, LF_SRC_SYNTH});
        apb(1'b1, 12'h304, 32'h2);
        apb(1'b1, 12'h008, 32'h1);
        rdc(12'h41c, 32'h2, "latched source");
        rdc(12'h414, 32'h1, "slow requested");
        chk("slow sel port", 32'h2, {30'h0, slow_source_sel});
        apb(1'b1, 12'h518, {30'h0, LF_SRC_XTAL});
        rdc(12'h518, 32'h2, "select locked");
        slow_clock_ready <= 1'b1;
        wait_irq();
        rdc(12'h104, 32'h1, "slow event");
        rdc(12'h418, 32'h00010002, "slow status");
        apb(1'b1, 12'h104, 32'h0);
        apb(1'b1, 12'h00c, 32'h1);
        rdc(12'h414, 32'h0, "slow stopped");
        chk("slow enable", 32'h0, {31'h0, slow_source_enable});
        slow_clock_ready <= 1'b0;
        apb(1'b1, 12'h518, {30'h0, LF_SRC_XTAL});
        rdc(12'h518, 32'h1, "select free");
        apb(1'b1, 12'h308, 32'h2);
    endtask : test_slow_clock

    task automatic test_timer();
        apb(1'b1, 12'h538, 32'h3);
        apb(1'b1, 12'h304, 32'h10);
        apb(1'b1, 12'h014, 32'h1);
        wait_irq();
        chk("timeout late", 32'h1, {31'h0, (n >= 3 * UNIT - 4) && (n <= 3 * UNIT + 4)});
        rdc(12'h110, 32'h1, "timeout event");
        apb(1'b1, 12'h110, 32'h0);
        repeat (40) @(posedge pclk);
        chk("timer halted", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h014, 32'h1);
        apb(1'b1, 12'h018, 32'h1);
        repeat (40) @(posedge pclk);
        rdc(12'h110, 32'h0, "stopped early");
    endtask : test_timer

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        failures = 0; cmp_count = 0; cal_pulses = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; fast_xtal_ready = 1'b0;
        slow_clock_ready = 1'b0; cal_complete = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_and_fields();
        test_mask_and_cal();
        test_fast_clock();
        test_slow_clock();
        test_timer();
        complete_run();
    end

    // whole run needs well under 2000 cycles
    initial begin
        #40000;
        failures++;
        complete_run();
    end
endmodule : tb_clock_source_ctrl_regs
